// ---- pkg/jl_pkg.sv ----
package jl_pkg;
  // ==========================================================================
  // Opcodes of the decoded group.
  localparam logic [7:0] OP_JUMP_ZERO = 8'h43;
  localparam logic [7:0] OP_CFG_PROG = 8'h1b;
  localparam logic [7:0] OP_CFG_RAM = 8'h14;
  localparam logic [7:0] OP_FUZ_RAM = 8'h18;
  localparam logic [7:0] OP_PER_PROG_IND = 8'h16;
  // ==========================================================================
  // Cycle counts per instruction.
  localparam logic [4:0] CYC_JUMP_TAKEN = 5'd11;
  localparam logic [4:0] CYC_JUMP_FALL = 5'd10;
  localparam logic [4:0] CYC_LOAD = 5'd14;
  localparam logic [4:0] CYC_LOAD_IND = 5'd17;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam int FUZ_REGS = 8;
  typedef enum logic [1:0] {
    TGT_NONE, TGT_CFG, TGT_FUZ, TGT_PER
  } target_type;
endpackage : jl_pkg

// ---- pkg/mem_if.sv ----
`timescale 1ns/1ps
interface mem_if;
  logic [15:0] addr;
  logic ram_sel;
  logic [7:0] rdata;
  modport seq (output addr, output ram_sel, input rdata);
  modport mux (input addr, input ram_sel, output rdata);
endinterface : mem_if

// ---- rtl/mem_mux.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Selects program memory or RAM read data onto one shared read path.
module mem_mux (
  mem_if.mux m,
  // Memory data.
  input wire logic [7:0] prog_rdata_i,
  input wire logic [7:0] ram_rdata_i,
  // Addresses out.
  output logic [15:0] prog_addr_o,
  output logic [7:0] ram_addr_o
);
  assign prog_addr_o = m.addr;
  assign ram_addr_o = m.addr[7:0];
  assign m.rdata = m.ram_sel ? ram_rdata_i : prog_rdata_i;
endmodule : mem_mux

// ---- rtl/jump_load_core.sv ----
`timescale 1ns/1ps
// Behaviour
// [RULE1] Jump when zero set, else continue.
// [RULE2] Jump takes eleven taken, ten otherwise.
// [RULE3] Jump is opcode, high then low address.
// [RULE4] Config load reads page*256 plus offset; the config RAM load reads RAM at the offset alone.
// [RULE5] Config program load: three bytes, fourteen cycles.
// [RULE6] Config RAM load copies RAM, fourteen cycles.
// [RULE7] Fuzzy load fills one of eight inputs.
// [RULE8] Fuzzy load: opcode, index, address; fourteen cycles.
// [RULE9] Peripheral load reads pointer, then program byte.
// [RULE10] Peripheral load: opcode, index, pointer; seventeen cycles.
// [RULE11] Paged loads use last selected page.
// [RULE12] Flags are never changed by this group.
module jump_load_core
  import jl_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Core state.
  input wire logic zero_flag_i, // RULE12
  input wire logic page_set_i,
  input wire logic [7:0] page_i,
  // Memories.
  input wire logic [7:0] prog_rdata_i,
  input wire logic [7:0] ram_rdata_i,
  output logic [15:0] prog_addr_o,
  output logic [7:0] ram_addr_o,
  // Register writes.
  output logic wr_en_o,
  output logic [1:0] wr_target_o,
  output logic [7:0] wr_index_o,
  output logic [7:0] wr_data_o,
  output logic [7:0] fuz_reg_o [FUZ_REGS],
  // Program flow.
  output logic [15:0] pc_o,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o
);
  // ==========================================================================
  // Sequencer.
  typedef enum logic [2:0] {
    S_OPC, S_B1, S_B2, S_PTR, S_DATA, S_WAIT
  } state_type;
  state_type state_q;
  logic [7:0] op_q, b1_q, page_q, ptr_q;
  logic [4:0] cnt_q, cyc_q;
  logic [15:0] addr_q, pc_q;
  logic ram_sel_q;
  mem_if m ();
  assign m.addr = addr_q;
  assign m.ram_sel = ram_sel_q;
  logic [15:0] prog_addr_w;
  logic [7:0] ram_addr_w;
  mem_mux u_mux (
    .m(m),
    .prog_rdata_i(prog_rdata_i),
    .ram_rdata_i(ram_rdata_i),
    .prog_addr_o(prog_addr_w),
    .ram_addr_o(ram_addr_w)
  );

  function automatic logic [15:0] paged(input logic [7:0] pg, input logic [7:0] off);
    paged = {pg, off};
  endfunction : paged

  wire logic known_w = (m.rdata == OP_JUMP_ZERO) || (m.rdata == OP_CFG_PROG) ||
    (m.rdata == OP_CFG_RAM) || (m.rdata == OP_FUZ_RAM) || (m.rdata == OP_PER_PROG_IND);
  wire logic is_jump_w = op_q == OP_JUMP_ZERO;
  wire logic take_w = is_jump_w && zero_flag_i; // RULE1
  wire logic [15:0] target_w = {b1_q, m.rdata}; // RULE3
  wire logic [4:0] need_w = is_jump_w ? (take_w ? CYC_JUMP_TAKEN : CYC_JUMP_FALL) // RULE2
    : (op_q == OP_PER_PROG_IND) ? CYC_LOAD_IND : CYC_LOAD; // RULE5 RULE6 RULE8 RULE10
  wire target_type tgt_w = (op_q == OP_FUZ_RAM) ? TGT_FUZ : // RULE7
    (op_q == OP_PER_PROG_IND) ? TGT_PER : TGT_CFG;
  wire logic src_prog_w = (op_q == OP_CFG_PROG); // RULE4
  wire logic [15:0] src_addr_w = src_prog_w ? paged(page_q, m.rdata) : {8'h00, m.rdata};

  // Page register tracks the separate page-select instruction.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      page_q <= PAGE_RESET;
    end else if (page_set_i) begin
      page_q <= page_i; // RULE11
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= S_OPC;
      op_q <= 8'h00;
      b1_q <= 8'h00;
      ptr_q <= 8'h00;
      cnt_q <= 5'd0;
      cyc_q <= 5'd0;
      pc_q <= PC_RESET;
      addr_q <= PC_RESET;
      ram_sel_q <= 1'b0;
      wr_en_o <= 1'b0;
      wr_target_o <= TGT_NONE;
      wr_index_o <= 8'h00;
      wr_data_o <= 8'h00;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      wr_en_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      cnt_q <= cnt_q + 5'd1;
      unique case (state_q)
        S_OPC: begin
          cnt_q <= 5'd1;
          if (known_w) begin
            op_q <= m.rdata;
            busy_o <= 1'b1;
            addr_q <= pc_q + 16'd1;
            state_q <= S_B1;
          end else begin
            illegal_o <= 1'b1;
            pc_q <= pc_q + 16'd1;
            addr_q <= pc_q + 16'd1;
          end
        end
        S_B1: begin
          b1_q <= m.rdata;
          addr_q <= pc_q + 16'd2;
          state_q <= S_B2;
        end
        S_B2: begin
          cyc_q <= need_w;
          if (is_jump_w) begin
            pc_q <= take_w ? target_w : pc_q + 16'd3; // RULE1
            state_q <= S_WAIT;
          end else begin
            pc_q <= pc_q + 16'd3;
            addr_q <= src_addr_w;
            ram_sel_q <= !src_prog_w;
            state_q <= (op_q == OP_PER_PROG_IND) ? S_PTR : S_DATA;
          end
        end
        S_PTR: begin
          ptr_q <= m.rdata;
          addr_q <= paged(page_q, m.rdata); // RULE9 RULE11
          ram_sel_q <= 1'b0;
          state_q <= S_DATA;
        end
        S_DATA: begin
          wr_en_o <= 1'b1;
          wr_target_o <= tgt_w;
          wr_index_o <= b1_q;
          wr_data_o <= m.rdata;
          ram_sel_q <= 1'b0;
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          addr_q <= pc_q;
          if (cnt_q >= cyc_q - 5'd1) begin
            done_o <= 1'b1;
            busy_o <= 1'b0;
            state_q <= S_OPC;
          end
        end
      endcase
    end
  end

  // Fuzzy input bank; entry n feeds fuzzy variable n+1.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < FUZ_REGS; i++) fuz_reg_o[i] <= 8'h00;
    end else if (state_q == S_DATA && tgt_w == TGT_FUZ && b1_q < 8'(FUZ_REGS)) begin
      fuz_reg_o[b1_q[2:0]] <= m.rdata; // RULE7
    end
  end

  // The memories answer combinationally, so the address leaves its flop directly.
  // A registered copy would make every read return the byte of the cycle before.
  assign prog_addr_o = prog_addr_w;
  assign ram_addr_o = ram_addr_w;
  assign pc_o = pc_q;

  // ==========================================================================
  // Checks. The flags are inputs only, so this group cannot alter them.
  logic [4:0] len_q;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || done_o) len_q <= 5'd0;
    else if (busy_o) len_q <= len_q + 5'd1;
  end
  jump_taken_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE1
    state_q == S_B2 && is_jump_w && zero_flag_i |=> pc_q == $past(target_w))
    else $error("taken jump did not load target");
  jump_fall_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE1
    state_q == S_B2 && is_jump_w && !zero_flag_i |=> pc_q == $past(pc_q) + 16'd3)
    else $error("fall-through pc wrong");
  jump_len_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE2
    done_o && is_jump_w |-> len_q == cyc_q - 5'd1)
    else $error("jump cycle count wrong");
  jump_decode_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE3
    state_q == S_OPC && m.rdata == OP_JUMP_ZERO |=> busy_o && op_q == OP_JUMP_ZERO)
    else $error("jump opcode not decoded");
  cfg_page_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE4
    state_q == S_B2 && op_q == OP_CFG_PROG |=> addr_q == {$past(page_q), $past(m.rdata)})
    else $error("paged address wrong");
  load_len_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE5
    done_o && op_q != OP_JUMP_ZERO && op_q != OP_PER_PROG_IND |-> len_q == 5'd13)
    else $error("load cycle count wrong");
  fuz_len_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE8
    done_o && op_q == OP_FUZ_RAM |-> len_q == CYC_LOAD - 5'd1)
    else $error("fuzzy load cycle count wrong");
  cfg_ram_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE6
    state_q == S_B2 && op_q == OP_CFG_RAM |=> ram_sel_q ##1 wr_en_o && wr_target_o == TGT_CFG)
    else $error("ram config load wrong");
  fuz_write_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE7
    state_q == S_DATA && op_q == OP_FUZ_RAM && b1_q < 8'd8 |=>
    fuz_reg_o[b1_q[2:0]] == $past(m.rdata))
    else $error("fuzzy input not written");
  per_ind_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE9
    state_q == S_PTR |=> addr_q == {page_q, ptr_q} && !ram_sel_q)
    else $error("indirect address wrong");
  ind_len_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE10
    done_o && op_q == OP_PER_PROG_IND |-> len_q == 5'd16)
    else $error("indirect load cycle count wrong");
  jump_cov_c: cover property (@(posedge core_clk_i) done_o && take_w);
  fall_cov_c: cover property (@(posedge core_clk_i) done_o && is_jump_w && !zero_flag_i);
  ind_cov_c: cover property (@(posedge core_clk_i) wr_en_o && wr_target_o == TGT_PER);
  fuz_cov_c: cover property (@(posedge core_clk_i) wr_en_o && wr_target_o == TGT_FUZ);
  cfg_cov_c: cover property (@(posedge core_clk_i) wr_en_o && wr_target_o == TGT_CFG);
endmodule : jump_load_core

// ---- test/mem_model.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Program memory and RAM seen by the core; reads answer combinationally.
module mem_model (
  // Addresses.
  input wire logic [15:0] prog_addr_i,
  input wire logic [7:0] ram_addr_i,
  // Read data.
  output logic [7:0] prog_rdata_o,
  output logic [7:0] ram_rdata_o
);
  logic [7:0] prog_mem [65536];
  logic [7:0] ram_mem [256];
  // Unloaded program space reads as an unknown opcode, so a runaway shows up.
  initial begin
    foreach (prog_mem[i]) prog_mem[i] = 8'hff;
    foreach (ram_mem[i]) ram_mem[i] = 8'h00;
  end
  assign prog_rdata_o = prog_mem[prog_addr_i];
  assign ram_rdata_o = ram_mem[ram_addr_i];
endmodule : mem_model

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import jl_pkg::*;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic zero_flag_i = 1'b0;
  logic page_set_i = 1'b0;
  logic [7:0] page_i = 8'h00;
  logic [7:0] prog_rdata, ram_rdata, wr_index, wr_data, last_index, last_data;
  logic [15:0] prog_addr, pc;
  logic [7:0] ram_addr;
  logic wr_en, busy, done, illegal;
  logic [1:0] wr_target, last_target;
  logic [7:0] fuz_reg [FUZ_REGS];
  logic saw_illegal = 1'b0;
  int n_fail = 0;
  int total_checks = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  jump_load_core u_jump_load_core (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .zero_flag_i(zero_flag_i), .page_set_i(page_set_i), .page_i(page_i),
    .prog_rdata_i(prog_rdata), .ram_rdata_i(ram_rdata), .prog_addr_o(prog_addr),
    .ram_addr_o(ram_addr), .wr_en_o(wr_en), .wr_target_o(wr_target),
    .wr_index_o(wr_index), .wr_data_o(wr_data), .fuz_reg_o(fuz_reg), .pc_o(pc),
    .busy_o(busy), .done_o(done), .illegal_o(illegal));
  mem_model u_mem_model (.prog_addr_i(prog_addr), .ram_addr_i(ram_addr),
    .prog_rdata_o(prog_rdata), .ram_rdata_o(ram_rdata));
  // The write strobe lasts one cycle, so its payload is latched for later checks.
  always @(posedge core_clk_i) begin
    if (wr_en === 1'b1) begin
      last_target <= wr_target;
      last_index <= wr_index;
      last_data <= wr_data;
    end
    if (illegal === 1'b1) saw_illegal <= 1'b1;
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Cycles from one completion pulse to the next equal the instruction length.
  task wait_done(output logic [15:0] n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
    end while (done !== 1'b1 && n < 40);
  endtask : wait_done
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task load_image;
    logic [7:0] a [9];
    logic [7:0] b [19];
    a = '{8'h43, 8'h00, 8'h10, 8'h43, 8'h00, 8'h20, 8'h43, 8'h01, 8'h00};
    b = '{8'h1b, 8'h0c, 8'h2c, 8'h14, 8'h0c, 8'h50, 8'h18, 8'h07, 8'h50, 8'h18,
      8'h08, 8'h50, 8'h16, 8'h02, 8'h1e, 8'hff, 8'h43, 8'h00, 8'h06};
    foreach (a[i]) u_mem_model.prog_mem[i] = a[i];
    foreach (b[i]) u_mem_model.prog_mem[16'h0100 + i] = b[i];
    u_mem_model.prog_mem[16'h012c] = 8'hf0;
    u_mem_model.prog_mem[16'h0130] = 8'h64;
    u_mem_model.ram_mem[8'h50] = 8'h40;
    u_mem_model.ram_mem[8'h1e] = 8'h30;
  endtask : load_image
  task jump_fall_check;
    logic [15:0] n;
    wait_done(n);
    check("fall length", n, 16'd10);
    check("fall pc", pc, 16'h0006);
  endtask : jump_fall_check
  task jump_taken_check;
    logic [15:0] n;
    zero_flag_i = 1'b1;
    wait_done(n);
    zero_flag_i = 1'b0;
    check("taken length", n, 16'd11);
    check("taken pc", pc, 16'h0100);
    check("idle at done", busy, 16'h0000);
  endtask : jump_taken_check
  task cfg_loads_check;
    logic [15:0] n;
    wait_done(n);
    check("cfg prog length", n, 16'd14);
    check("cfg prog data", {last_target, last_index, last_data}, {TGT_CFG, 16'h0cf0});
    wait_done(n);
    check("cfg ram length", n, 16'd14);
    check("cfg ram data", {last_target, last_index, last_data}, {TGT_CFG, 16'h0c40});
  endtask : cfg_loads_check
  task fuzzy_check;
    logic [15:0] n;
    wait_done(n);
    check("fuzzy length", n, 16'd14);
    check("fuzzy reg 7", fuz_reg[7], 16'h0040);
    wait_done(n);
    check("fuzzy bad index reg 0", fuz_reg[0], 16'h0000);
    check("fuzzy bad index reg 7", fuz_reg[7], 16'h0040);
  endtask : fuzzy_check
  task periph_check;
    logic [15:0] n;
    wait_done(n);
    check("periph length", n, 16'd17);
    check("periph data", {last_target, last_index, last_data}, {TGT_PER, 16'h0264});
    repeat (4) @(posedge core_clk_i);
    #1;
    check("illegal flagged", saw_illegal, 16'h0001);
  endtask : periph_check
  initial begin
    repeat (20) @(posedge core_clk_i);
    // Loaded after time zero so the model's own fill cannot overwrite the image.
    load_image();
    #1 srst_i = 1'b0;
    // Two page selections; only the later one must govern the paged loads.
    @(posedge core_clk_i);
    #1 page_set_i = 1'b1;
    page_i = 8'h03;
    @(posedge core_clk_i);
    #1 page_i = 8'h01;
    @(posedge core_clk_i);
    #1 page_set_i = 1'b0;
    wait (done === 1'b1);
    #1;
    jump_fall_check();
    jump_taken_check();
    cfg_loads_check();
    fuzzy_check();
    periph_check();
    complete_run();
  end
  initial begin
    #(25 * 3000);
    n_fail++;
    complete_run();
  end
endmodule : testbench
